// [common/msc_defs.svh]
`ifndef MSC_DEFS_SVH
`define MSC_DEFS_SVH

// clock and timing
`define MSC_CLK_NS 8
`define MSC_RST_MIN_NS 10000
`define MSC_INIT_NS 2000000
`define MSC_RST_MIN_CYC ((`MSC_RST_MIN_NS + `MSC_CLK_NS - 1) / `MSC_CLK_NS)
`define MSC_INIT_CYC (`MSC_INIT_NS / `MSC_CLK_NS)
`define MSC_LOW_W 16
`define MSC_CNT_W 24

// register byte addresses
`define MSC_ADDR_CTRL 32'h0000_0000
`define MSC_ADDR_STATUS 32'h0000_0004
`define MSC_ADDR_IRQ_STAT 32'h0000_0008
`define MSC_ADDR_IRQ_MASK 32'h0000_000C

// decoded register index
`define MSC_IDX_CTRL 3'h0
`define MSC_IDX_STATUS 3'h1
`define MSC_IDX_IRQ_STAT 3'h2
`define MSC_IDX_IRQ_MASK 3'h3
`define MSC_IDX_NONE 3'h7

// control fields
`define MSC_CTRL_HPEN 0
`define MSC_CTRL_ALT 1

// event bits: init done, loss change ch1/ch2, fault rise ch1/ch2
`define MSC_EV_W 5
`define MSC_EV_INIT 0
`define MSC_EV_LOS 1
`define MSC_EV_FLT 3
`define MSC_MASK_RST 5'h1F

// synchronised pin vector layout
`define MSC_PIN_W 12
`define MSC_P_RST 0
`define MSC_P_LP 1
`define MSC_P_RXR 2
`define MSC_P_TXR 4
`define MSC_P_TXOFF 6
`define MSC_P_LOS 8
`define MSC_P_FLT 10
`define MSC_PIN_RST_VAL 12'h003

// bus responses
`define MSC_RESP_OKAY 2'h0
`define MSC_RESP_SLVERR 2'h2

`endif

// [common/msc_pkg.sv]
`include "msc_defs.svh"

package msc_pkg;

typedef enum logic [3:0] {
    MSC_ST_RESET = 4'h1,
    MSC_ST_INIT = 4'h2,
    MSC_ST_LOW = 4'h4,
    MSC_ST_HIGH = 4'h8
} msc_state_t;

typedef struct packed {
    logic [`MSC_PIN_W-1:0] s1;
    logic [`MSC_PIN_W-1:0] s2;
    msc_state_t st;
    logic [`MSC_LOW_W-1:0] low_cnt;
    logic [`MSC_CNT_W-1:0] cnt;
    logic dnr;
    logic hp_en;
    logic irq_alt;
    logic [`MSC_EV_W-1:0] mask;
    logic [`MSC_EV_W-1:0] stat;
    logic awv;
    logic wv;
    logic [2:0] widx;
    logic [31:0] wdata;
    logic wstb;
    logic awrdy;
    logic wrdy;
    logic bvalid;
    logic [1:0] bresp;
    logic arrdy;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic irq;
    logic irq_n;
    logic [1:0] los;
    logic [1:0] flt;
    logic [1:0] tx_dis;
    logic [1:0] rx_rate;
    logic [1:0] tx_rate;
    logic hp;
    logic [3:0] pads;
} msc_regs_t;

endpackage

// [src/msc_sideband.sv]
// Summary of operation
// - four rate-select inputs are weakly pulled low inside the device.
// - rx rate-select pins choose receive rate of channels 1 and 2.
// - tx rate-select pins choose transmit rate of channels 1 and 2.
// - reset pin low beyond minimum length restores every setting to default.
// - initialisation period starts at the rising edge ending reset.
// - completion is signalled by the interrupt with data-not-ready negated.
// - after power-up the completion interrupt is posted without a pulse.
// - reset input is pulled up internally, undriven reads inactive.
// - presence line is tied low by the device.
// - low-power input is active high and pulled up internally.
// - with low-power asserted, stay low power until software enables high.
// - with low-power low, enter high power once initialised.
// - interrupt pin may be reconfigured as channel 2 transmit fault.
// - each transmitter-disable input disables only its own channel.
// - receive loss of signal is reported per channel.
`timescale 1ns/1ns
`default_nettype none
`include "msc_defs.svh"

module msc_sideband #(
    parameter int INIT_CYC = `MSC_INIT_CYC
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // register bus
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    // host sideband pins
    input wire logic module_reset_n,
    input wire logic low_power_req,
    input wire logic rx_rate_sel_ch1,
    input wire logic rx_rate_sel_ch2,
    input wire logic tx_rate_sel_ch1,
    input wire logic tx_rate_sel_ch2,
    input wire logic tx_off_ch1,
    input wire logic tx_off_ch2,
    output logic module_absent_n,
    output logic irq_n,
    output logic tx_fault_ch1,
    output logic rx_signal_lost_ch1,
    output logic rx_signal_lost_ch2,
    // pad pull enables
    output logic rate_sel_pulldown_en,
    output logic reset_pullup_en,
    output logic low_power_pullup_en,
    // optical front end
    input wire logic [1:0] rx_los_raw,
    input wire logic [1:0] tx_fault_raw,
    output logic [1:0] rx_rate_ctl,
    output logic [1:0] tx_rate_ctl,
    output logic [1:0] tx_laser_off,
    output logic high_power,
    output logic data_not_ready,
    // interrupt
    output logic irq
);
    import msc_pkg::*;

    msc_regs_t r_reg;
    msc_regs_t r_next;
    logic [`MSC_PIN_W-1:0] pins;
    logic rst_pin;
    logic lp_pin;

    // address decode to register index
    function automatic logic [2:0] msc_dec(input logic [31:0] a);
        logic [2:0] idx;
        idx = `MSC_IDX_NONE;
        if (a == `MSC_ADDR_CTRL) begin
            idx = `MSC_IDX_CTRL;
        end else if (a == `MSC_ADDR_STATUS) begin
            idx = `MSC_IDX_STATUS;
        end else if (a == `MSC_ADDR_IRQ_STAT) begin
            idx = `MSC_IDX_IRQ_STAT;
        end else if (a == `MSC_ADDR_IRQ_MASK) begin
            idx = `MSC_IDX_IRQ_MASK;
        end
        return idx;
    endfunction

    assign pins = {tx_fault_raw, rx_los_raw, tx_off_ch2, tx_off_ch1,
        tx_rate_sel_ch2, tx_rate_sel_ch1, rx_rate_sel_ch2, rx_rate_sel_ch1,
        low_power_req, module_reset_n};
    assign rst_pin = r_reg.s2[`MSC_P_RST];
    assign lp_pin = r_reg.s2[`MSC_P_LP];

    always_comb begin
        logic [`MSC_EV_W-1:0] clr;
        logic [`MSC_EV_W-1:0] ev;
        logic [2:0] ridx;
        logic long_rst;
        clr = '0;
        ev = '0;
        ridx = msc_dec(s_axi_araddr);
        long_rst = 1'b0;
        r_next = r_reg;
        // pin synchronisers
        r_next.s1 = pins;
        r_next.s2 = r_reg.s1;

        // read channel
        if (r_reg.rvalid && s_axi_rready) begin
            r_next.rvalid = 1'b0;
        end
        if (s_axi_arvalid && r_reg.arrdy) begin
            r_next.rvalid = 1'b1;
            r_next.rresp = `MSC_RESP_OKAY;
            r_next.rdata = '0;
            unique case (ridx)
                `MSC_IDX_CTRL: begin
                    r_next.rdata[`MSC_CTRL_HPEN] = r_reg.hp_en;
                    r_next.rdata[`MSC_CTRL_ALT] = r_reg.irq_alt;
                end
                `MSC_IDX_STATUS: begin
                    r_next.rdata[12:0] = {r_reg.flt, r_reg.los,
                        r_reg.s2[`MSC_P_TXOFF +: 2], r_reg.tx_rate,
                        r_reg.rx_rate, lp_pin, r_reg.hp, r_reg.dnr};
                    r_next.rdata[15:12] = r_reg.st;
                end
                `MSC_IDX_IRQ_STAT: begin
                    r_next.rdata[`MSC_EV_W-1:0] = r_reg.stat;
                    clr = r_reg.stat;
                end
                `MSC_IDX_IRQ_MASK: begin
                    r_next.rdata[`MSC_EV_W-1:0] = r_reg.mask;
                end
                default: begin
                    r_next.rresp = `MSC_RESP_SLVERR;
                end
            endcase
        end
        r_next.arrdy = !r_next.rvalid;

        // write channels, address and data in either order
        if (r_reg.bvalid && s_axi_bready) begin
            r_next.bvalid = 1'b0;
        end
        if (s_axi_awvalid && r_reg.awrdy) begin
            r_next.awv = 1'b1;
            r_next.widx = msc_dec(s_axi_awaddr);
        end
        if (s_axi_wvalid && r_reg.wrdy) begin
            r_next.wv = 1'b1;
            r_next.wdata = s_axi_wdata;
            r_next.wstb = s_axi_wstrb[0];
        end
        if (r_reg.awv && r_reg.wv && !r_reg.bvalid) begin
            r_next.awv = 1'b0;
            r_next.wv = 1'b0;
            r_next.bvalid = 1'b1;
            r_next.bresp = `MSC_RESP_OKAY;
            if (r_reg.widx == `MSC_IDX_CTRL) begin
                if (r_reg.wstb) begin
                    r_next.hp_en = r_reg.wdata[`MSC_CTRL_HPEN];
                    r_next.irq_alt = r_reg.wdata[`MSC_CTRL_ALT];
                end
            end else if (r_reg.widx == `MSC_IDX_IRQ_MASK) begin
                if (r_reg.wstb) begin
                    r_next.mask = r_reg.wdata[`MSC_EV_W-1:0];
                end
            end else if (r_reg.widx == `MSC_IDX_NONE) begin
                r_next.bresp = `MSC_RESP_SLVERR;
            end
        end
        r_next.awrdy = !r_next.awv && !r_next.bvalid;
        r_next.wrdy = !r_next.wv && !r_next.bvalid;

        // reset pin pulse measurement
        if (!rst_pin) begin
            if (r_reg.low_cnt != '1) begin
                r_next.low_cnt = r_reg.low_cnt + 16'h0001;
            end
            if (r_reg.low_cnt == `MSC_LOW_W'(`MSC_RST_MIN_CYC - 1)) begin
                long_rst = 1'b1;
            end
        end else begin
            r_next.low_cnt = '0;
        end

        // power state machine
        unique case (r_reg.st)
            MSC_ST_RESET: begin
                r_next.dnr = 1'b1;
                if (rst_pin) begin
                    r_next.st = MSC_ST_INIT;
                    r_next.cnt = '0;
                end
            end
            MSC_ST_INIT: begin
                r_next.cnt = r_reg.cnt + 24'h00_0001;
                if (r_reg.cnt == `MSC_CNT_W'(INIT_CYC - 1)) begin
                    r_next.dnr = 1'b0;
                    ev[`MSC_EV_INIT] = 1'b1;
                    r_next.st = MSC_ST_LOW;
                end
            end
            MSC_ST_LOW: begin
                if (!lp_pin || r_reg.hp_en) begin
                    r_next.st = MSC_ST_HIGH;
                end
            end
            MSC_ST_HIGH: begin
                if (lp_pin && !r_reg.hp_en) begin
                    r_next.st = MSC_ST_LOW;
                end
            end
        endcase

        // sideband outputs
        r_next.los = r_reg.s2[`MSC_P_LOS +: 2];
        r_next.flt = r_reg.s2[`MSC_P_FLT +: 2];
        r_next.rx_rate = r_reg.s2[`MSC_P_RXR +: 2];
        r_next.tx_rate = r_reg.s2[`MSC_P_TXR +: 2];
        ev[`MSC_EV_LOS +: 2] = r_next.los ^ r_reg.los;
        ev[`MSC_EV_FLT +: 2] = r_next.flt & ~r_reg.flt;

        if (long_rst) begin
            r_next.st = MSC_ST_RESET;
            r_next.dnr = 1'b1;
            r_next.hp_en = 1'b0;
            r_next.irq_alt = 1'b0;
            r_next.mask = `MSC_MASK_RST;
            r_next.stat = '0;
        end else begin
            r_next.stat = (r_reg.stat & ~clr) | ev;
        end

        r_next.hp = (r_next.st == MSC_ST_HIGH);
        // each disable reaches only its own transmitter
        r_next.tx_dis = r_reg.s2[`MSC_P_TXOFF +: 2] | {2{!r_next.hp}};
        r_next.irq = |(r_next.stat & r_next.mask);
        r_next.irq_n = r_next.irq_alt ? r_next.flt[1] : !r_next.irq;
        // pulls: rate down, reset up, low-power up; presence tied low
        r_next.pads = 4'h7;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r_reg <= '0;
            r_reg.s1 <= `MSC_PIN_RST_VAL;
            r_reg.s2 <= `MSC_PIN_RST_VAL;
            r_reg.st <= MSC_ST_INIT;
            r_reg.dnr <= 1'b1;
            r_reg.mask <= `MSC_MASK_RST;
            r_reg.irq_n <= 1'b1;
            r_reg.tx_dis <= 2'h3;
            r_reg.pads <= 4'h7;
        end else begin
            r_reg <= r_next;
        end
    end

    assign s_axi_awready = r_reg.awrdy;
    assign s_axi_wready = r_reg.wrdy;
    assign s_axi_bvalid = r_reg.bvalid;
    assign s_axi_bresp = r_reg.bresp;
    assign s_axi_arready = r_reg.arrdy;
    assign s_axi_rvalid = r_reg.rvalid;
    assign s_axi_rdata = r_reg.rdata;
    assign s_axi_rresp = r_reg.rresp;
    assign module_absent_n = r_reg.pads[3];
    assign irq_n = r_reg.irq_n;
    assign tx_fault_ch1 = r_reg.flt[0];
    assign rx_signal_lost_ch1 = r_reg.los[0];
    assign rx_signal_lost_ch2 = r_reg.los[1];
    assign rate_sel_pulldown_en = r_reg.pads[0];
    assign reset_pullup_en = r_reg.pads[1];
    assign low_power_pullup_en = r_reg.pads[2];
    assign rx_rate_ctl = r_reg.rx_rate;
    assign tx_rate_ctl = r_reg.tx_rate;
    assign tx_laser_off = r_reg.tx_dis;
    assign high_power = r_reg.hp;
    assign data_not_ready = r_reg.dnr;
    assign irq = r_reg.irq;

    // checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_long_reset: assert property (
        (!rst_pin && r_reg.low_cnt == `MSC_LOW_W'(`MSC_RST_MIN_CYC - 1))
        |=> (r_reg.st == MSC_ST_RESET && !r_reg.hp_en && !r_reg.irq_alt
            && r_reg.dnr))
        else $error("long reset pulse did not restore defaults");
    a_short_pulse: assert property (
        (!rst_pin && r_reg.low_cnt < `MSC_LOW_W'(`MSC_RST_MIN_CYC - 1)
            && r_reg.st != MSC_ST_RESET)
        |=> r_reg.st != MSC_ST_RESET)
        else $error("short reset pulse caused a reset");
    a_init_start: assert property (
        (r_reg.st == MSC_ST_RESET && rst_pin && r_reg.low_cnt != '0)
        |=> (r_reg.st == MSC_ST_INIT && r_reg.cnt == '0))
        else $error("init period did not start on reset release");
    a_init_done: assert property (
        (r_reg.st == MSC_ST_INIT && r_reg.cnt == `MSC_CNT_W'(INIT_CYC - 1)
            && rst_pin)
        |=> (!r_reg.dnr && r_reg.stat[`MSC_EV_INIT]
            && (r_reg.irq == |(r_reg.mask & r_reg.stat))))
        else $error("completion not posted after init");
    a_init_dnr: assert property (
        (r_reg.st == MSC_ST_INIT || r_reg.st == MSC_ST_RESET) |-> r_reg.dnr)
        else $error("data not ready negated before init completion");
    a_lp_hold: assert property (
        (r_reg.st == MSC_ST_LOW && lp_pin && !r_reg.hp_en && rst_pin)
        |=> r_reg.st == MSC_ST_LOW)
        else $error("left low power without software enable");
    a_hp_enter: assert property (
        (r_reg.st == MSC_ST_LOW && !lp_pin && rst_pin)
        |=> (r_reg.st == MSC_ST_HIGH && r_reg.hp))
        else $error("high power not entered with low-power released");
    a_irq_pin: assert property (
        r_reg.irq_alt |-> ##1 (!r_reg.irq_alt
            || r_reg.irq_n == $past(r_reg.s2[`MSC_P_FLT + 1])))
        else $error("interrupt pin not carrying ch2 fault");
    a_irq_level: assert property (
        !r_reg.irq_alt |-> (r_reg.irq_n == !r_reg.irq))
        else $error("interrupt pin not active low of interrupt");
    a_tx_off: assert property (
        r_reg.hp |-> r_reg.tx_dis == $past(r_reg.s2[`MSC_P_TXOFF +: 2]))
        else $error("disable input not honoured per channel");
    a_lowpower_off: assert property (
        !r_reg.hp |-> r_reg.tx_dis == '1)
        else $error("transmitter enabled in low power");
    a_rate_follow: assert property (
        ##1 (r_reg.rx_rate == $past(r_reg.s2[`MSC_P_RXR +: 2])
            && r_reg.tx_rate == $past(r_reg.s2[`MSC_P_TXR +: 2])))
        else $error("rate select outputs not following pins");
    a_fault_follow: assert property (
        ##1 (r_reg.flt == $past(r_reg.s2[`MSC_P_FLT +: 2])))
        else $error("fault outputs not following front end");
    a_presence_low: assert property (!module_absent_n)
        else $error("presence line not tied low");
    a_pulls_on: assert property (
        rate_sel_pulldown_en && reset_pullup_en && low_power_pullup_en)
        else $error("pad pull enables not active");
    // bus handshake holds, unmapped read error, loss of signal follow
    a_rdata_hold: assert property (
        (r_reg.rvalid && !s_axi_rready) |=> (r_reg.rvalid
            && r_reg.rdata == $past(r_reg.rdata)))
        else $error("read data dropped before accepted");
    a_wresp_hold: assert property (
        (r_reg.bvalid && !s_axi_bready) |=> (r_reg.bvalid
            && r_reg.bresp == $past(r_reg.bresp)))
        else $error("write response dropped before accepted");
    a_rd_slverr: assert property (
        (s_axi_arvalid && r_reg.arrdy
            && msc_dec(s_axi_araddr) == `MSC_IDX_NONE)
        |=> r_reg.rresp == `MSC_RESP_SLVERR)
        else $error("unmapped read not refused");
    a_los_follow: assert property (
        r_reg.s2[`MSC_P_LOS +: 2] != r_reg.los |=> r_reg.los == $past(
            r_reg.s2[`MSC_P_LOS +: 2]))
        else $error("loss of signal output not following input");

    c_long_reset: cover property (r_reg.st == MSC_ST_RESET ##1 rst_pin);
    c_init_done: cover property ($fell(r_reg.dnr));
    c_high_power: cover property ($rose(r_reg.hp));
    c_irq_alt: cover property (r_reg.irq_alt && !r_reg.irq_n);
    c_short_pulse: cover property (!rst_pin ##1 (rst_pin && r_reg.hp));
endmodule

`default_nettype wire

// [testbench/msc_host_model.sv]
`timescale 1ns/1ns
`default_nettype none

module msc_host_model (
    // clock
    input wire logic aclk,
    // bench commands
    input wire logic cmd_reset_n,
    input wire logic cmd_lp,
    input wire logic [3:0] cmd_rate,
    input wire logic [1:0] cmd_off,
    input wire logic cmd_float,
    // module pads
    input wire logic rate_sel_pulldown_en,
    input wire logic reset_pullup_en,
    input wire logic low_power_pullup_en,
    input wire logic module_absent_n,
    input wire logic irq_n,
    output logic module_reset_n,
    output logic low_power_req,
    output logic [3:0] rate_pins,
    output logic [1:0] off_pins,
    output logic present,
    output logic status_ok
);
    // host board pull-up, module pulls low
    assign present = (module_absent_n === 1'b0);
    always @(posedge aclk) begin
        off_pins <= cmd_off;
        if (cmd_float) begin
            // released pins settle to the pull, else they drift
            rate_pins <= rate_sel_pulldown_en ? 4'h0 : ~rate_pins;
            low_power_req <= low_power_pullup_en ? 1'b1 : ~low_power_req;
            module_reset_n <= reset_pullup_en ? 1'b1 : ~module_reset_n;
        end else begin
            rate_pins <= cmd_rate;
            low_power_req <= cmd_lp;
            module_reset_n <= cmd_reset_n;
        end
        // status trusted only after the completion interrupt
        if (!module_reset_n) begin
            status_ok <= 1'b0;
        end else if (irq_n === 1'b0) begin
            status_ok <= 1'b1;
        end
    end
endmodule

`default_nettype wire

// [testbench/tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
`include "msc_defs.svh"

module tb_top;
    localparam int INIT = 20;
    localparam int LIMIT = 6000;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic [31:0] awaddr = 32'h0000_0000, wdata = 32'h0000_0000;
    logic [31:0] araddr = 32'h0000_0000;
    logic [1:0] los_raw = 2'h0, flt_raw = 2'h0, cmd_off = 2'h0;
    logic cmd_reset_n = 1'b1, cmd_lp = 1'b1, cmd_float = 1'b0;
    logic [3:0] cmd_rate = 4'h0;
    int err_total = 0, checks = 0, cyc = 0;
    wire awready, wready, bvalid, arready, rvalid, lp_pin, rst_pin;
    wire [1:0] bresp, rresp, rx_rate_ctl, tx_rate_ctl, tx_laser_off, off_pins;
    wire [31:0] rdata;
    wire [3:0] rate_pins;
    wire absent_n, irq_n, flt1, lost1, lost2, pd_en, pu_rst, pu_lp;
    wire high_power, data_not_ready, irq, present, status_ok;
    logic [31:0] d;
    logic [1:0] r;

    msc_sideband #(.INIT_CYC(INIT)) u_msc_sideband (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .module_reset_n(rst_pin), .low_power_req(lp_pin),
        .rx_rate_sel_ch1(rate_pins[0]), .rx_rate_sel_ch2(rate_pins[1]),
        .tx_rate_sel_ch1(rate_pins[2]), .tx_rate_sel_ch2(rate_pins[3]),
        .tx_off_ch1(off_pins[0]), .tx_off_ch2(off_pins[1]),
        .module_absent_n(absent_n), .irq_n(irq_n), .tx_fault_ch1(flt1),
        .rx_signal_lost_ch1(lost1), .rx_signal_lost_ch2(lost2),
        .rate_sel_pulldown_en(pd_en), .reset_pullup_en(pu_rst),
        .low_power_pullup_en(pu_lp), .rx_los_raw(los_raw),
        .tx_fault_raw(flt_raw), .rx_rate_ctl(rx_rate_ctl),
        .tx_rate_ctl(tx_rate_ctl), .tx_laser_off(tx_laser_off),
        .high_power(high_power), .data_not_ready(data_not_ready), .irq(irq)
    );

    msc_host_model u_msc_host_model (
        .aclk(aclk), .cmd_reset_n(cmd_reset_n), .cmd_lp(cmd_lp),
        .cmd_rate(cmd_rate), .cmd_off(cmd_off), .cmd_float(cmd_float),
        .rate_sel_pulldown_en(pd_en), .reset_pullup_en(pu_rst),
        .low_power_pullup_en(pu_lp), .module_absent_n(absent_n),
        .irq_n(irq_n), .module_reset_n(rst_pin), .low_power_req(lp_pin),
        .rate_pins(rate_pins), .off_pins(off_pins), .present(present),
        .status_ok(status_ok)
    );

    initial begin
        forever #4 aclk = ~aclk;
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            err_total++;
            final_report();
        end
    end

    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
        #1;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] v);
        logic done;
        done = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (awvalid && awready === 1'b1)
                awvalid <= 1'b0;
            if (wvalid && wready === 1'b1)
                wvalid <= 1'b0;
            if (bvalid === 1'b1) begin
                r = bresp;
                bready <= 1'b0;
                done = 1'b1;
            end
        end
        chk("write resp", 32'h0000_0000, {30'h0, r});
    endtask

    task automatic rd(input logic [31:0] a);
        logic done;
        done = 1'b0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (arvalid && arready === 1'b1)
                arvalid <= 1'b0;
            if (rvalid === 1'b1) begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask

    task automatic fe(input logic [1:0] l, input logic [1:0] f);
        @(posedge aclk);
        los_raw <= l;
        flt_raw <= f;
        tick(6);
    endtask

    task automatic wait_irq();
        for (int i = 0; i < INIT + 20 && irq_n !== 1'b0; i++)
            tick(1);
        tick(1);
    endtask

    task automatic t_powerup();
        tick(1);
        chk("dnr in init", 1, data_not_ready);
        wait_irq();
        chk("irq_n", 0, irq_n);
        chk("dnr", 0, data_not_ready);
        chk("present", 1, present);
        chk("status ok", 1, status_ok);
        chk("high_power", 0, high_power);
        chk("laser off", 3, tx_laser_off);
        rd(`MSC_ADDR_IRQ_STAT);
        chk("irq_stat", 1, d);
        tick(2);
        chk("irq_n clr", 1, irq_n);
        $display("test powerup done");
    endtask

    task automatic t_pins();
        cmd_rate = 4'h9;
        tick(6);
        chk("rx rate", 1, rx_rate_ctl);
        chk("tx rate", 2, tx_rate_ctl);
        cmd_float = 1'b1;
        tick(6);
        chk("rx rate float", 0, rx_rate_ctl);
        chk("tx rate float", 0, tx_rate_ctl);
        chk("dnr float", 0, data_not_ready);
        chk("hp float", 0, high_power);
        cmd_float = 1'b0;
        wr(`MSC_ADDR_CTRL, 32'h0000_0001);
        tick(6);
        chk("hp enabled", 1, high_power);
        cmd_off = 2'h1;
        tick(6);
        chk("off ch1", 1, tx_laser_off);
        cmd_off = 2'h2;
        tick(6);
        chk("off ch2", 2, tx_laser_off);
        rd(`MSC_ADDR_STATUS);
        chk("status", 32'h0000_814E, d);
        $display("test pins done");
    endtask

    task automatic t_irq();
        wr(`MSC_ADDR_IRQ_MASK, 32'h0000_0000);
        fe(2'h2, 2'h0);
        chk("lost ch1", 0, lost1);
        chk("lost ch2", 1, lost2);
        chk("irq masked", 0, irq);
        rd(`MSC_ADDR_IRQ_STAT);
        chk("stat masked", 32'h0000_0004, d);
        wr(`MSC_ADDR_IRQ_MASK, 32'h0000_001F);
        fe(2'h3, 2'h0);
        chk("lost ch1 set", 1, lost1);
        chk("irq", 1, irq);
        rd(`MSC_ADDR_IRQ_STAT);
        chk("stat los1", 32'h0000_0002, d);
        tick(2);
        chk("irq clr", 0, irq);
        rd(32'h0000_0010);
        chk("unmapped", 2, r);
        $display("test irq done");
    endtask

    task automatic t_alt();
        wr(`MSC_ADDR_CTRL, 32'h0000_0003);
        fe(2'h3, 2'h2);
        chk("alt fault2", 1, irq_n);
        chk("fault1", 0, flt1);
        fe(2'h3, 2'h1);
        chk("alt clear", 0, irq_n);
        chk("fault1 set", 1, flt1);
        wr(`MSC_ADDR_CTRL, 32'h0000_0001);
        rd(`MSC_ADDR_IRQ_STAT);
        chk("stat faults", 32'h0000_0018, d);
        fe(2'h3, 2'h0);
        chk("irq_n default", 1, irq_n);
        $display("test alt done");
    endtask

    task automatic t_resets();
        cmd_reset_n = 1'b0;
        tick(100);
        cmd_reset_n = 1'b1;
        tick(6);
        rd(`MSC_ADDR_CTRL);
        chk("ctrl kept", 1, d);
        chk("hp kept", 1, high_power);
        cmd_reset_n = 1'b0;
        tick(1300);
        chk("dnr reset", 1, data_not_ready);
        chk("hp reset", 0, high_power);
        rd(`MSC_ADDR_CTRL);
        chk("ctrl reset", 0, d);
        rd(`MSC_ADDR_IRQ_MASK);
        chk("mask reset", 32'h0000_001F, d);
        cmd_reset_n = 1'b1;
        tick(6);
        chk("init runs", 1, data_not_ready);
        wait_irq();
        chk("dnr done", 0, data_not_ready);
        chk("status ok", 1, status_ok);
        chk("still low", 0, high_power);
        cmd_lp = 1'b0;
        tick(6);
        chk("hp lp low", 1, high_power);
        $display("test resets done");
    endtask

    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        t_powerup();
        t_pins();
        t_irq();
        t_alt();
        t_resets();
        final_report();
    end
endmodule

`default_nettype wire
